// file: design/pac_pkg.sv
// Package of register map, field positions and constants for the block.
package pac_pkg;
  // ****************************************************
  // Register offsets (byte addresses) and reset values.
  // ****************************************************
  localparam logic [8:0]  PAC_PHY_ACS_OFF   = 9'h014;
  localparam logic [8:0]  PAC_GLOB_OFF      = 9'h018;
  localparam logic [8:0]  PAC_PKCTL_OFF     = 9'h020;
  localparam logic [31:0] PAC_PHY_ACS_RST   = 32'h0000_0000;
  localparam logic [31:0] PAC_GLOB_RST      = 32'h0001_0000;
  localparam logic [31:0] PAC_PKCTL_RST     = 32'h0000_0001;
  // ****************************************************
  // Field positions.
  // ****************************************************
  localparam int PAC_RD_CMD_BIT   = 31;
  localparam int PAC_WR_CMD_BIT   = 30;
  localparam int PAC_TADDR_LSB    = 24;
  localparam int PAC_WVAL_LSB     = 16;
  localparam int PAC_RADDR_LSB    = 8;
  localparam int PAC_RVAL_LSB     = 0;
  localparam int PAC_GATE_LSB     = 8;
  localparam int PAC_DIR_BIT      = 16;
  localparam int PAC_TRANSPORT_DELAY_LSB    = 16;
  localparam int PAC_MAX_BLOCKS_PER_PAYLOAD_LSB    = 8;
  localparam int PAC_TXEN_BIT     = 4;
  localparam int PAC_TXRST_BIT    = 0;
  localparam int PAC_CYC_LSB      = 12;
  // ****************************************************
  // Cycle timer limits and the automatic read target.
  // ****************************************************
  localparam logic [3:0]  PAC_OFF_HI_WRAP   = 4'hC;
  localparam logic [12:0] PAC_CYC_WRAP      = 13'h1F40;
  localparam logic [3:0]  PAC_AUTO_ADDR     = 4'h0;
  typedef enum logic [1:0] {PAC_IDLE, PAC_SEND, PAC_WAIT} pac_st_e;
endpackage : pac_pkg

// file: design/pac_stamp.sv
// Time stamp adder: cycle timer plus transport delay.
`timescale 1ns/1ps
`default_nettype none
module pac_stamp (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [24:0] cycle_timer,
  input  wire logic [11:0] transport_delay,
  output logic      [24:0] time_stamp
);
  import pac_pkg::*;
  logic [24:0] stamp_q;
  logic [24:0] stamp_d;
  logic [4:0]  hi_sum;
  logic [13:0] cyc_sum;
  logic        carry;
  // ****************************************************
  // Adder.
  // ****************************************************
  always_comb begin
    // [R13] delay addition
    hi_sum = {1'b0, cycle_timer[11:8]} + {1'b0, transport_delay[3:0]};
    carry  = (hi_sum >= {1'b0, PAC_OFF_HI_WRAP});
    if (carry) begin
      hi_sum = hi_sum - {1'b0, PAC_OFF_HI_WRAP};
    end
    // [R17] cycle timer fields
    cyc_sum = {1'b0, cycle_timer[24:PAC_CYC_LSB]}
            + {6'h00, transport_delay[11:4]} + {13'h0000, carry};
    if (cyc_sum >= {1'b0, PAC_CYC_WRAP}) begin
      cyc_sum = cyc_sum - {1'b0, PAC_CYC_WRAP};
    end
    stamp_d = {cyc_sum[12:0], hi_sum[3:0], cycle_timer[7:0]};
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stamp_q <= 25'h000_0000;
    end else begin
      stamp_q <= stamp_d;
    end
  end
  assign time_stamp = stamp_q;
endmodule // pac_stamp
`default_nettype wire

// file: design/pac_regs.sv
// Register bank: PHY access, interrupt summary, transmit packing control.
//
// Overview of operation
// [R1] Read command bit 31 sends a read request, then clears when sent.
// [R2] Write command bit 30 sends address and data, then clears when sent.
// [R3] Completed PHY read sets the read-received flag, marking data valid.
// [R4] Returned data sits in bits 7..0, its address in bits 11..8.
// [R5] Host issues no new command before the previous one completes.
// [R6] After Self-ID ends, PHY register 0 is read automatically.
// [R7] Summary bits 0..3 show pending link/PHY, receive, transmit, async.
// [R8] Summary bits need no acknowledge and follow their module state.
// [R9] Gate bits 8..11 allow each module to drive the interrupt.
// [R10] Active-low interrupt stays asserted while any enabled source pends.
// [R11] Direction bit 16, reset 1, selects transmitter and sets pin direction.
// [R12] Packing parameters stay fixed while the transmitter runs.
// [R13] Time stamp adds transport delay to offset high bits and cycle.
// [R14] Each payload carries at most the max-blocks count of blocks.
// [R15] Transmit enable runs the transmitter; clearing ends after current packet.
// [R16] Bit 0 resets the transmitter while high; held one AV clock.
// [R17] Cycle timer gives 12-bit offset and 13-bit cycle number.
// [R18] Writes to read-only fields are ignored.
`timescale 1ns/1ps
`default_nettype none
module pac_regs (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        hst_cs,
  input  wire logic        hst_wr,
  input  wire logic        hst_rd,
  input  wire logic [8:0]  hst_addr,
  input  wire logic [7:0]  hst_wdata,
  output logic      [7:0]  hst_rdata,
  output logic             phy_req_valid,
  input  wire logic        phy_req_ready,
  output logic             phy_req_write,
  output logic      [3:0]  phy_req_addr,
  output logic      [7:0]  phy_req_data,
  input  wire logic        phy_rsp_valid,
  input  wire logic [3:0]  phy_rsp_addr,
  input  wire logic [7:0]  phy_rsp_data,
  input  wire logic        self_id_done,
  input  wire logic        lp_rrx_enable,
  input  wire logic        lp_rrx_clear,
  input  wire logic        lp_other_active,
  input  wire logic        irx_active,
  input  wire logic        itx_active,
  input  wire logic        asy_active,
  output logic             phy_read_received_flag,
  output logic             host_irq_n,
  output logic             av_pins_oe,
  output logic             iso_tx_reset,
  output logic             app_accept,
  output logic             tx_arbitrate,
  input  wire logic        pkt_busy,
  input  wire logic        blk_take,
  input  wire logic        payload_close,
  output logic             payload_room,
  input  wire logic [24:0] cycle_timer,
  output logic      [24:0] time_stamp
);
  import pac_pkg::*;
  // ****************************************************
  // State.
  // ****************************************************
  logic [31:0] acs_q, acs_d, glob_q, glob_d, pk_q, pk_d;
  pac_st_e     st_q, st_d;
  logic        auto_q, auto_d, rrx_q, rrx_d, run_q, run_d, irq_n_q, irq_n_d;
  logic        cur_wr_q, cur_wr_d, auto_cur_q, auto_cur_d;
  logic [3:0]  cur_ad_q, cur_ad_d;
  logic [8:0]  blk_q, blk_d;
  logic [7:0]  rdat_q, rdat_d;
  logic [3:0]  pend;
  logic        wr_acs, wr_glob, wr_pk, rd_hit;
  logic [31:0] rword;
  function automatic logic [31:0] put_byte(input logic [31:0] w,
      input logic [1:0] ln, input logic [7:0] b);
    logic [31:0] r;
    r = w;
    r[{ln, 3'b000} +: 8] = b;
    return r;
  endfunction
  assign wr_acs  = hst_cs && hst_wr && (hst_addr[8:2] == PAC_PHY_ACS_OFF[8:2]);
  assign wr_glob = hst_cs && hst_wr && (hst_addr[8:2] == PAC_GLOB_OFF[8:2]);
  assign wr_pk   = hst_cs && hst_wr && (hst_addr[8:2] == PAC_PKCTL_OFF[8:2]);
  // ****************************************************
  // PHY access engine and its register.
  // ****************************************************
  always_comb begin
    acs_d      = acs_q;
    st_d       = st_q;
    auto_d     = auto_q || self_id_done;
    cur_wr_d   = cur_wr_q;
    cur_ad_d   = cur_ad_q;
    auto_cur_d = auto_cur_q;
    rrx_d      = rrx_q;
    unique case (st_q)
      PAC_IDLE: begin
        if (acs_q[PAC_RD_CMD_BIT] || acs_q[PAC_WR_CMD_BIT]) begin
          st_d       = PAC_SEND;
          cur_wr_d   = !acs_q[PAC_RD_CMD_BIT];
          cur_ad_d   = acs_q[PAC_TADDR_LSB +: 4];
          auto_cur_d = 1'b0;
        end else if (auto_q) begin
          // [R6] automatic register 0 read
          st_d       = PAC_SEND;
          cur_wr_d   = 1'b0;
          cur_ad_d   = PAC_AUTO_ADDR;
          auto_cur_d = 1'b1;
          auto_d     = self_id_done;
        end
      end
      PAC_SEND: begin
        if (phy_req_ready) begin
          st_d = cur_wr_q ? PAC_IDLE : PAC_WAIT;
          // [R1] [R2] command bit clear
          if (!auto_cur_q) begin
            if (cur_wr_q) begin
              acs_d[PAC_WR_CMD_BIT] = 1'b0;
            end else begin
              acs_d[PAC_RD_CMD_BIT] = 1'b0;
            end
          end
        end
      end
      PAC_WAIT: begin
        if (phy_rsp_valid) begin
          st_d = PAC_IDLE;
        end
      end
    endcase
    // [R4] returned value capture
    if (phy_rsp_valid) begin
      acs_d[PAC_RVAL_LSB +: 8]  = phy_rsp_data;
      acs_d[PAC_RADDR_LSB +: 4] = phy_rsp_addr;
    end
    // [R3] read received flag, set wins
    if (lp_rrx_clear) begin
      rrx_d = 1'b0;
    end
    if (st_q == PAC_WAIT && phy_rsp_valid) begin
      rrx_d = 1'b1;
    end
    // [R18] read-only fields kept
    if (wr_acs && hst_addr[1:0] >= 2'd2) begin
      acs_d = put_byte(acs_d, hst_addr[1:0], hst_wdata);
      acs_d[29:28] = 2'b00;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      acs_q      <= PAC_PHY_ACS_RST;
      st_q       <= PAC_IDLE;
      auto_q     <= 1'b0;
      cur_wr_q   <= 1'b0;
      cur_ad_q   <= 4'h0;
      auto_cur_q <= 1'b0;
      rrx_q      <= 1'b0;
    end else begin
      acs_q      <= acs_d;
      st_q       <= st_d;
      auto_q     <= auto_d;
      cur_wr_q   <= cur_wr_d;
      cur_ad_q   <= cur_ad_d;
      auto_cur_q <= auto_cur_d;
      rrx_q      <= rrx_d;
    end
  end
  assign phy_req_valid = (st_q == PAC_SEND);
  assign phy_req_write = cur_wr_q;
  assign phy_req_addr  = cur_ad_q;
  assign phy_req_data  = acs_q[PAC_WVAL_LSB +: 8];
  assign phy_read_received_flag = rrx_q;
  // ****************************************************
  // Interrupt summary, gates and direction.
  // ****************************************************
  // [R7] [R8] live summary
  assign pend = {asy_active, itx_active, irx_active,
                 lp_other_active || (rrx_q && lp_rrx_enable)};
  always_comb begin
    glob_d = glob_q;
    // [R9] [R11] [R18] writable bits only
    if (wr_glob && hst_addr[1:0] == 2'd1) begin
      glob_d[PAC_GATE_LSB +: 4] = hst_wdata[3:0];
    end
    if (wr_glob && hst_addr[1:0] == 2'd2) begin
      glob_d[PAC_DIR_BIT] = hst_wdata[0];
    end
    // [R10] interrupt output
    irq_n_d = !(|(pend & glob_q[PAC_GATE_LSB +: 4]));
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      glob_q  <= PAC_GLOB_RST;
      irq_n_q <= 1'b1;
    end else begin
      glob_q  <= glob_d;
      irq_n_q <= irq_n_d;
    end
  end
  assign host_irq_n = irq_n_q;
  // [R11] pin direction
  assign av_pins_oe = glob_q[PAC_DIR_BIT];
  // ****************************************************
  // Transmit packing control.
  // ****************************************************
  always_comb begin
    pk_d = pk_q;
    if (wr_pk) begin
      pk_d = put_byte(pk_q, hst_addr[1:0], hst_wdata);
    end
    // [R15] graceful shutdown
    run_d = pk_q[PAC_TXEN_BIT] || (run_q && pkt_busy);
    if (pk_q[PAC_TXRST_BIT]) begin
      run_d = 1'b0;
    end
    // [R14] block count limit
    blk_d = blk_q;
    if (payload_close || pk_q[PAC_TXRST_BIT]) begin
      blk_d = 9'h000;
    end else if (blk_take && payload_room) begin
      blk_d = blk_q + 9'h001;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pk_q  <= PAC_PKCTL_RST;
      run_q <= 1'b0;
      blk_q <= 9'h000;
    end else begin
      pk_q  <= pk_d;
      run_q <= run_d;
      blk_q <= blk_d;
    end
  end
  // [R16] transmitter reset level
  assign iso_tx_reset = pk_q[PAC_TXRST_BIT];
  assign app_accept   = pk_q[PAC_TXEN_BIT] && !pk_q[PAC_TXRST_BIT];
  assign tx_arbitrate = run_q;
  assign payload_room = (blk_q < {1'b0, pk_q[PAC_MAX_BLOCKS_PER_PAYLOAD_LSB +: 8]});
  pac_stamp u_stamp (
    .clk_sys         (clk_sys),
    .rstn            (rstn),
    .cycle_timer     (cycle_timer),
    .transport_delay (pk_q[PAC_TRANSPORT_DELAY_LSB +: 12]),
    .time_stamp      (time_stamp)
  );
  // ****************************************************
  // Host read port.
  // ****************************************************
  always_comb begin
    rd_hit = 1'b1;
    unique case (hst_addr[8:2])
      PAC_PHY_ACS_OFF[8:2]: rword = acs_q;
      PAC_GLOB_OFF[8:2]:    rword = {glob_q[31:4], pend};
      PAC_PKCTL_OFF[8:2]:   rword = pk_q;
      default: begin
        rword  = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
    rdat_d = rdat_q;
    if (hst_cs && hst_rd) begin
      rdat_d = rd_hit ? rword[{hst_addr[1:0], 3'b000} +: 8] : 8'h00;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdat_q <= 8'h00;
    end else begin
      rdat_q <= rdat_d;
    end
  end
  assign hst_rdata = rdat_q;
  // ****************************************************
  // Assertions.
  // ****************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_rd_clear;
    st_q == PAC_SEND && phy_req_ready && !cur_wr_q && !auto_cur_q
      && !wr_acs |=> !acs_q[PAC_RD_CMD_BIT];
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read cmd stuck"); // [R1]
  property p_wr_req;
    $rose(acs_q[PAC_WR_CMD_BIT]) && st_q == PAC_IDLE
      |=> phy_req_valid && phy_req_write;
  endproperty
  a_wr_req: assert property (p_wr_req) else $error("no write request"); // [R2]
  property p_rrx;
    st_q == PAC_WAIT && phy_rsp_valid |=> phy_read_received_flag;
  endproperty
  a_rrx: assert property (p_rrx) else $error("flag not set"); // [R3]
  property p_rdata;
    phy_rsp_valid |=> acs_q[7:0] == $past(phy_rsp_data)
      && acs_q[11:8] == $past(phy_rsp_addr);
  endproperty
  a_rdata: assert property (p_rdata) else $error("data not kept"); // [R4]
  property p_auto;
    self_id_done && st_q == PAC_IDLE && !acs_q[31] && !acs_q[30]
      |=> ##1 phy_req_valid && phy_req_addr == PAC_AUTO_ADDR;
  endproperty
  a_auto: assert property (p_auto) else $error("no auto read"); // [R6]
  property p_irq;
    |(pend & glob_q[11:8]) |=> !host_irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not low"); // [R10]
  property p_gate;
    (glob_q[11:8] == 4'h0) [*2] |-> host_irq_n;
  endproperty
  a_gate: assert property (p_gate) else $error("irq leaks"); // [R9]
  property p_dir;
    wr_glob && hst_addr[1:0] == 2'd2 |=> av_pins_oe == $past(hst_wdata[0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong"); // [R11]
  property p_run;
    !pk_q[PAC_TXEN_BIT] && !pkt_busy |=> !tx_arbitrate;
  endproperty
  a_run: assert property (p_run) else $error("tx still runs"); // [R15]
  property p_blk;
    blk_take && !payload_room && !payload_close && !pk_q[PAC_TXRST_BIT]
      |=> blk_q == $past(blk_q);
  endproperty
  a_blk: assert property (p_blk) else $error("too many blocks"); // [R14]
  c_read: cover property (st_q == PAC_WAIT ##[1:20] phy_rsp_valid);
  c_write: cover property (phy_req_valid && phy_req_write && phy_req_ready);
  c_irq: cover property ($fell(host_irq_n));
endmodule // pac_regs
`default_nettype wire

// file: tb/pac_phy_model.sv
// Behavioural PHY that takes register requests and answers reads.
`timescale 1ns/1ps
`default_nettype none
module pac_phy_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       phy_req_valid,
  input  wire logic       phy_req_write,
  input  wire logic [3:0] phy_req_addr,
  input  wire logic [7:0] phy_req_data,
  input  wire logic [3:0] stall,
  output logic            phy_req_ready = 1'b0,
  output logic            phy_rsp_valid = 1'b0,
  output logic      [3:0] phy_rsp_addr = 4'h0,
  output logic      [7:0] phy_rsp_data = 8'h00,
  output logic            got_write,
  output logic      [3:0] got_addr,
  output logic      [7:0] got_data,
  output int              n_taken
);
  logic [3:0] wait_q;
  logic [3:0] rsp_q;
  logic [3:0] radr_q;
  // Released answer lines toggle so stale values never look valid.
  always @(posedge clk_sys) begin
    phy_req_ready <= 1'b0;
    phy_rsp_valid <= 1'b0;
    phy_rsp_addr <= ~phy_rsp_addr;
    phy_rsp_data <= ~phy_rsp_data;
    if (!rstn) begin
      wait_q <= 4'h0;
      rsp_q <= 4'h0;
      n_taken <= 0;
    end else begin
      if (phy_req_valid && !phy_req_ready) begin
        wait_q <= (wait_q == stall) ? 4'h0 : wait_q + 4'h1;
        phy_req_ready <= (wait_q == stall);
      end
      if (phy_req_valid && phy_req_ready) begin
        n_taken <= n_taken + 1;
        got_write <= phy_req_write;
        got_addr <= phy_req_addr;
        got_data <= phy_req_data;
        radr_q <= phy_req_addr;
        if (!phy_req_write) rsp_q <= 4'h3;
      end
      if (rsp_q == 4'h1) begin
        phy_rsp_valid <= 1'b1;
        phy_rsp_addr <= radr_q;
        phy_rsp_data <= 8'h5A ^ {4'h0, radr_q};
      end
      if (rsp_q != 4'h0) rsp_q <= rsp_q - 4'h1;
    end
  end
endmodule // pac_phy_model
`default_nettype wire

// file: tb/phy_access_irq_summary_txctl_test.sv
// Self-checking bench for the PHY access and interrupt summary bank.
`timescale 1ns/1ps
`default_nettype none
module phy_access_irq_summary_txctl_test;
  import pac_pkg::*;
  localparam logic [8:0] AC = PAC_PHY_ACS_OFF;
  localparam logic [8:0] GB = PAC_GLOB_OFF;
  localparam logic [8:0] PK = PAC_PKCTL_OFF;
  logic clk_sys = 1'b0, rstn = 1'b0, hst_cs = 1'b0, hst_wr = 1'b0;
  logic hst_rd = 1'b0, self_id_done = 1'b0, lp_rrx_enable = 1'b0;
  logic lp_rrx_clear = 1'b0, pkt_busy = 1'b0, blk_take = 1'b0;
  logic payload_close = 1'b0;
  logic [8:0] hst_addr = 9'h000;
  logic [7:0] hst_wdata = 8'h00;
  logic [3:0] act = 4'h0, stall = 4'h0;
  logic [24:0] cycle_timer = 25'h000_0000;
  wire logic lp_other_active = act[0];
  wire logic irx_active = act[1];
  wire logic itx_active = act[2];
  wire logic asy_active = act[3];
  logic [7:0] hst_rdata, phy_req_data, phy_rsp_data, got_data, d;
  logic [3:0] phy_req_addr, phy_rsp_addr, got_addr;
  logic phy_req_valid, phy_req_ready, phy_req_write, phy_rsp_valid;
  logic phy_read_received_flag, host_irq_n, av_pins_oe, iso_tx_reset;
  logic app_accept, tx_arbitrate, payload_room, got_write;
  logic [24:0] time_stamp;
  int n_taken, mismatches = 0, total_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  pac_regs i_dut (
    .clk_sys                (clk_sys),
    .rstn                   (rstn),
    .hst_cs                 (hst_cs),
    .hst_wr                 (hst_wr),
    .hst_rd                 (hst_rd),
    .hst_addr               (hst_addr),
    .hst_wdata              (hst_wdata),
    .hst_rdata              (hst_rdata),
    .phy_req_valid          (phy_req_valid),
    .phy_req_ready          (phy_req_ready),
    .phy_req_write          (phy_req_write),
    .phy_req_addr           (phy_req_addr),
    .phy_req_data           (phy_req_data),
    .phy_rsp_valid          (phy_rsp_valid),
    .phy_rsp_addr           (phy_rsp_addr),
    .phy_rsp_data           (phy_rsp_data),
    .self_id_done           (self_id_done),
    .lp_rrx_enable          (lp_rrx_enable),
    .lp_rrx_clear           (lp_rrx_clear),
    .lp_other_active        (lp_other_active),
    .irx_active             (irx_active),
    .itx_active             (itx_active),
    .asy_active             (asy_active),
    .phy_read_received_flag (phy_read_received_flag),
    .host_irq_n             (host_irq_n),
    .av_pins_oe             (av_pins_oe),
    .iso_tx_reset           (iso_tx_reset),
    .app_accept             (app_accept),
    .tx_arbitrate           (tx_arbitrate),
    .pkt_busy               (pkt_busy),
    .blk_take               (blk_take),
    .payload_close          (payload_close),
    .payload_room           (payload_room),
    .cycle_timer            (cycle_timer),
    .time_stamp             (time_stamp)
  );
  pac_phy_model i_phy (
    .clk_sys       (clk_sys),
    .rstn          (rstn),
    .phy_req_valid (phy_req_valid),
    .phy_req_write (phy_req_write),
    .phy_req_addr  (phy_req_addr),
    .phy_req_data  (phy_req_data),
    .stall         (stall),
    .phy_req_ready (phy_req_ready),
    .phy_rsp_valid (phy_rsp_valid),
    .phy_rsp_addr  (phy_rsp_addr),
    .phy_rsp_data  (phy_rsp_data),
    .got_write     (got_write),
    .got_addr      (got_addr),
    .got_data      (got_data),
    .n_taken       (n_taken)
  );
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bad(input string m);
    mismatches++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk_val(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e) bad(m);
  endtask
  task automatic chk_bit(input logic g, e, input string m);
    total_checks++;
    if (g !== e) bad(m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    hst_cs = 1'b1;
    hst_wr = 1'b1;
    hst_addr = a;
    hst_wdata = v;
    tick(1);
    hst_cs = 1'b0;
    hst_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [8:0] a);
    hst_cs = 1'b1;
    hst_rd = 1'b1;
    hst_addr = a;
    tick(1);
    hst_cs = 1'b0;
    hst_rd = 1'b0;
    d = hst_rdata;
    tick(1);
  endtask
  task automatic wait_phy(input int c, input logic need_flag);
    int n;
    n = 0;
    while ((n_taken < c || (need_flag && !phy_read_received_flag))
           && n < 60) begin
      tick(1);
      n++;
    end
    if (n == 60) begin
      bad("phy timeout");
      print_verdict;
    end
  endtask
  task automatic clr_flag;
    lp_rrx_clear = 1'b1;
    tick(1);
    lp_rrx_clear = 1'b0;
    tick(1);
  endtask
  task automatic pulse(input logic close);
    payload_close = close;
    blk_take = !close;
    tick(1);
    payload_close = 1'b0;
    blk_take = 1'b0;
    tick(1);
  endtask
  task automatic t_reset;
    chk_bit(av_pins_oe, 1'b1, "dir reset");
    chk_bit(host_irq_n, 1'b1, "irq reset");
    chk_bit(iso_tx_reset, 1'b1, "txrst reset");
    chk_bit(payload_room, 1'b0, "room reset");
    rd(GB + 9'h002);
    chk_val(d, 8'h01, "glob reset");
    rd(PK);
    chk_val(d, 8'h01, "pk reset");
    rd(AC + 9'h003);
    chk_val(d, 8'h00, "acs reset");
    rd(9'h100);
    chk_val(d, 8'h00, "unmapped");
  endtask
  task automatic t_phy_read;
    lp_rrx_enable = 1'b1;
    stall = 4'h3;
    wr(GB + 9'h001, 8'h01);
    wr(AC + 9'h003, 8'h85);
    wait_phy(1, 1'b1);
    chk_val({got_write, got_addr}, 5'h05, "read req");
    wr(AC, 8'hFF);
    wr(AC + 9'h001, 8'hFF);
    chk_bit(phy_read_received_flag, 1'b1, "flag kept");
    rd(AC);
    chk_val(d, 8'h5F, "read value");
    rd(AC + 9'h001);
    chk_val(d, 8'h05, "read addr");
    rd(AC + 9'h003);
    chk_val(d, 8'h05, "rd cmd clear");
    chk_bit(host_irq_n, 1'b0, "irq on read");
    rd(GB);
    chk_val(d, 8'h01, "sum link");
    clr_flag;
    chk_bit(host_irq_n, 1'b1, "irq gone");
    rd(GB);
    chk_val(d, 8'h00, "sum clear");
  endtask
  task automatic t_phy_write;
    stall = 4'h0;
    wr(AC + 9'h002, 8'hC3);
    wr(AC + 9'h003, 8'h4A);
    wait_phy(2, 1'b0);
    tick(1);
    chk_val({got_write, got_addr, got_data}, 13'h1AC3, "wr req");
    rd(AC + 9'h003);
    chk_val(d, 8'h0A, "wr cmd clear");
    chk_bit(phy_read_received_flag, 1'b0, "no flag");
  endtask
  task automatic t_auto_read;
    self_id_done = 1'b1;
    tick(1);
    self_id_done = 1'b0;
    wait_phy(3, 1'b1);
    chk_val({got_write, got_addr}, 5'h00, "auto read");
    rd(AC + 9'h001);
    chk_val(d, 8'h00, "auto addr");
    rd(AC);
    chk_val(d, 8'h5A, "auto value");
    clr_flag;
  endtask
  task automatic t_gates;
    for (int i = 0; i < 4; i++) begin
      act = 4'h1 << i;
      wr(GB + 9'h001, ~(8'h01 << i) & 8'h0F);
      tick(1);
      chk_bit(host_irq_n, 1'b1, "gated off");
      rd(GB);
      chk_val(d, {4'h0, act}, "summary");
      wr(GB + 9'h001, 8'h01 << i);
      tick(1);
      chk_bit(host_irq_n, 1'b0, "gated on");
      act = 4'h0;
      tick(2);
      chk_bit(host_irq_n, 1'b1, "source gone");
    end
    act = 4'hF;
    tick(2);
    rd(GB);
    chk_val(d, 8'h0F, "all pending");
    act = 4'h0;
  endtask
  task automatic t_dir;
    wr(GB + 9'h002, 8'h00);
    tick(1);
    chk_bit(av_pins_oe, 1'b0, "rx dir");
    wr(GB + 9'h002, 8'h01);
    tick(1);
    chk_bit(av_pins_oe, 1'b1, "tx dir");
  endtask
  task automatic t_tx;
    wr(PK + 9'h002, 8'h13);
    cycle_timer = 25'h0_52AB;
    tick(2);
    chk_val(time_stamp, 25'h0_65AB, "stamp");
    cycle_timer = 25'h1F3_FAFF;
    tick(2);
    chk_val(time_stamp, 25'h0_11FF, "stamp wrap");
    wr(PK + 9'h003, 8'h01);
    cycle_timer = 25'h0_52AB;
    tick(2);
    chk_val(time_stamp, 25'h1_65AB, "stamp hi");
    wr(PK + 9'h001, 8'h02);
    wr(PK, 8'h11);
    tick(1);
    chk_bit(app_accept, 1'b0, "held reset");
    wr(PK, 8'h10);
    tick(1);
    chk_bit(app_accept, 1'b1, "accept");
    chk_bit(iso_tx_reset, 1'b0, "reset low");
    chk_bit(tx_arbitrate, 1'b1, "arbitrate");
    pulse(1'b0);
    chk_bit(payload_room, 1'b1, "room one");
    pulse(1'b0);
    chk_bit(payload_room, 1'b0, "room full");
    pulse(1'b0);
    chk_bit(payload_room, 1'b0, "room capped");
    pulse(1'b1);
    chk_bit(payload_room, 1'b1, "room new");
    pkt_busy = 1'b1;
    wr(PK, 8'h00);
    tick(2);
    chk_bit(tx_arbitrate, 1'b1, "finish pkt");
    chk_bit(app_accept, 1'b0, "no accept");
    pkt_busy = 1'b0;
    tick(2);
    chk_bit(tx_arbitrate, 1'b0, "shut down");
  endtask
  initial begin
    tick(6);
    rstn = 1'b1;
    tick(1);
    t_reset;
    t_phy_read;
    t_phy_write;
    t_auto_read;
    t_gates;
    t_dir;
    t_tx;
    print_verdict;
  end
endmodule // phy_access_irq_summary_txctl_test
`default_nettype wire
